// ### logic/buck1_map.svh
// register indices, field codes, reset values and timing constants of the buck1 control block
`ifndef BUCK1_MAP_SVH
`define BUCK1_MAP_SVH

// system clock period
`define BUCK1_CLK_NS 20

// register indices; byte address is the index shifted by two
`define BUCK1_SETUP_A_IDX 16'h4056
`define BUCK1_SETUP_B_IDX 16'h4057
`define BUCK1_STATUS_IDX 16'h4058
`define BUCK1_IDX_SHIFT 2
`define BUCK1_REG_W 16

// status word bit positions
`define BUCK1_STS_UV_BIT 0
`define BUCK1_STS_RAMP_BIT 4
`define BUCK1_STS_HC_BIT 8

// reset values
`define BUCK1_RAMP_RST 2'h2
`define BUCK1_INVERT_RST 1'b0
`define BUCK1_RATE_SEL_RST 2'h0
`define BUCK1_FLOAT_RST 1'b0
`define BUCK1_SS_RST 2'h0
`define BUCK1_CAP_RST 2'h0
`define BUCK1_SRC_RST 2'h0
`define BUCK1_VPICK_RST 1'b0
`define BUCK1_THR_RST 3'h0
`define BUCK1_DET_RST 1'b0

// ramp interval codes
`define BUCK1_RAMP_FASTEST 2'h2
`define BUCK1_RAMP_IMMEDIATE 2'h3

// hardware control source bits
`define BUCK1_HWC_IN1_BIT 0
`define BUCK1_HWC_IN2_BIT 1

// timing: shortest ramp interval and shortest soft-start step
`define BUCK1_RAMP_FAST_NS 8000
`define BUCK1_SS_SHORT_NS 32000
`define BUCK1_SS_LAST 3'h7
`define BUCK1_TMR_W 16

`endif

// ### logic/buck1_pkg.sv
// types shared by the buck1 control block
package buck1_pkg;

  typedef logic [6:0] vcode_t;

  typedef enum logic [1:0] {
    MODE_FCCM = 2'b00,
    MODE_OFF = 2'b01,
    MODE_LDO = 2'b10,
    MODE_HYST = 2'b11
  } op_mode_t;

  typedef enum logic [1:0] {
    UV_IGNORE = 2'b00,
    UV_CONV_OFF = 2'b01,
    UV_SYS_RESET = 2'b10,
    UV_RESERVED = 2'b11
  } uv_action_t;

  typedef enum logic [1:0] {
    PS_OFF = 2'b00,
    PS_SOFTSTART = 2'b01,
    PS_RUN = 2'b10
  } power_state_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_WAIT = 1'b1
  } bus_state_t;

  // first control register, laid out bit for bit
  typedef struct packed {
    logic [1:0] buck1_ramp_interval;
    logic rsv13;
    logic buck1_clock_invert;
    logic [1:0] rsv11_10;
    logic [1:0] buck1_switch_rate_sel;
    logic buck1_output_float;
    logic rsv6;
    logic [1:0] buck1_softstart_step;
    logic [1:0] rsv3_2;
    logic [1:0] buck1_capacitor_range;
  } setup_a_t;

  // second control register, laid out bit for bit
  typedef struct packed {
    uv_action_t buck1_undervoltage_action;
    logic rsv13;
    logic [1:0] buck1_hwctl_source;
    logic buck1_hwctl_voltage_pick;
    op_mode_t buck1_hwctl_op_mode;
    logic rsv7;
    logic [2:0] buck1_overload_threshold;
    logic [2:0] rsv3_1;
    logic buck1_overload_detect_en;
  } setup_b_t;

  // everything the analogue stage receives
  typedef struct packed {
    logic enable;
    logic discharge;
    logic clock_invert;
    logic [1:0] switch_rate_sel;
    logic [1:0] capacitor_range;
    op_mode_t op_mode;
    logic [2:0] softstart_level;
    logic [2:0] overload_threshold;
    logic overload_detect_en;
    vcode_t voltage;
  } stage_ctrl_t;

endpackage

// ### logic/pin_sync.sv
// three-stage pin synchroniser; the output moves once stages two and three agree
module pin_sync #(
  parameter int unsigned W = 4
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // pins and filtered levels
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] level_o
);
  genvar g;
  generate
    for (g = 0; g < W; g++)
    begin : g_bit
      logic s1_reg, s2_reg, s3_reg, lvl_reg;
      logic lvl_next;
      always_comb
      begin
        lvl_next = (s2_reg == s3_reg) ? s3_reg : lvl_reg;
      end
      always_ff @(posedge clk_i or negedge rst_b_i)
      begin
        if (!rst_b_i)
        begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
          s3_reg <= 1'b0;
          lvl_reg <= 1'b0;
        end
        else
        begin
          s1_reg <= pin_i[g];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          lvl_reg <= lvl_next;
        end
      end
      assign level_o[g] = lvl_reg;
    end
  endgenerate
endmodule

// ### logic/step_timer.sv
// interval timer: one-cycle tick every period cycles while run is high
module step_timer #(
  parameter int unsigned W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // control
  input wire logic run_i,
  input wire logic [W-1:0] period_i,
  // tick
  output logic tick_o
);
  logic [W-1:0] cnt_reg, cnt_next;
  logic tick_reg, tick_next;

  always_comb
  begin
    cnt_next = '0;
    tick_next = 1'b0;
    // restart from zero whenever run drops so each interval is whole
    if (run_i)
    begin
      if (cnt_reg + W'(1) >= period_i)
        tick_next = 1'b1;
      else
        cnt_next = cnt_reg + W'(1);
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;
endmodule

// ### logic/buck1_control.sv
// buck1 control registers with ramp, soft-start, hardware control and undervoltage handling
//
// How it works
// RQ1: ramp code picks 32/16/8us steps or immediate
// RQ2: ramp field bits 15:14, resets to 10
// RQ3: bit 12 inverts switching clock phase
// RQ4: bits 9:8 pick 2MHz or 4MHz
// RQ5: frequency and capacitor writable only during config load
// RQ6: bit 7 floats output, else discharges when off
// RQ7: eight soft-start steps of 32 to 256us
// RQ8: bits 1:0 tell output capacitor range
// RQ9: undervoltage action: ignore, converter off, system reset
// RQ10: every undervoltage event raises an interrupt
// RQ11: bits 12:11 pick hardware control input
// RQ12: bit 10 picks on or sleep voltage
// RQ13: bits 9:8 mode under hardware control, reset 11
// RQ14: threshold code gives 125mA times code plus one
// RQ15: bit 0 enables high-current detection
// RQ16: undervoltage flag follows undervoltage condition
// RQ17: overload flag high while current exceeds threshold
// RQ18: voltage steps once per interval until target
// RQ19: hardware settings apply only while input asserted
//
// Chosen here: the AHB-Lite interface to the registers.
`include "buck1_map.svh"

module buck1_control #(
  parameter int unsigned TW = `BUCK1_TMR_W,
  parameter int unsigned RAMP_BASE_CYCLES = `BUCK1_RAMP_FAST_NS / `BUCK1_CLK_NS,
  parameter int unsigned SS_BASE_CYCLES = `BUCK1_SS_SHORT_NS / `BUCK1_CLK_NS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // configuration loader, same clock
  input wire logic otp_load_i,
  input wire logic eeprom_config_load_i,
  // settings held by neighbouring registers, same clock
  input wire logic enable_i,
  input wire buck1_pkg::op_mode_t normal_mode_i,
  input wire buck1_pkg::vcode_t buck1_on_voltage_i,
  input wire buck1_pkg::vcode_t buck1_sleep_voltage_i,
  // asynchronous pins
  input wire logic hwctl1_i,
  input wire logic hwctl2_i,
  input wire logic undervoltage_i,
  input wire logic overload_i,
  // analogue stage
  output buck1_pkg::stage_ctrl_t stage_o,
  // status and events
  output logic buck1_undervoltage_flag_o,
  output logic buck1_overload_flag_o,
  output logic uv_irq_o,
  output logic sys_reset_req_o
);
  import buck1_pkg::*;

  // reset release
  logic [1:0] rst_pipe_reg;
  logic rst_n;

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      rst_pipe_reg <= 2'h0;
    else
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
  end
  assign rst_n = rst_pipe_reg[1];

  // pin synchronisers
  logic [3:0] pins_s;
  logic hw1_s, hw2_s, uv_s, oc_s;

  pin_sync #(.W(4)) u_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_n),
    .pin_i({overload_i, undervoltage_i, hwctl2_i, hwctl1_i}),
    .level_o(pins_s)
  );
  assign {oc_s, uv_s, hw2_s, hw1_s} = pins_s;

  // state declarations
  bus_state_t bus_reg, bus_next;
  logic [31:0] addr_reg, addr_next;
  logic wr_reg, wr_next;
  logic ready_reg, ready_next;
  logic [31:0] rdata_reg, rdata_next;
  setup_a_t a_reg, a_next;
  setup_b_t b_reg, b_next;
  power_state_t ps_reg, ps_next;
  logic [2:0] ss_reg, ss_next;
  vcode_t vout_reg, vout_next;
  logic conv_off_reg, conv_off_next;
  logic uv_prev_reg, uv_prev_next;
  logic irq_reg, irq_next;
  logic rstreq_reg, rstreq_next;
  logic uvf_reg, uvf_next;
  logic hcf_reg, hcf_next;
  stage_ctrl_t stage_reg, stage_next;

  // shared combinational terms
  logic cfg_load;
  logic hw_active;
  op_mode_t eff_mode;
  vcode_t target;
  logic want_on;
  logic uv_rise;
  logic ramp_run, ramp_tick, ss_tick;
  logic [TW-1:0] ramp_period, ss_period;
  logic [`BUCK1_REG_W-1:0] status_word;
  logic [31:0] idx;

  assign cfg_load = otp_load_i | eeprom_config_load_i;

  // bus and register file
  always_comb
  begin
    setup_a_t wa;
    setup_b_t wb;
    wa = setup_a_t'(hwdata_i[`BUCK1_REG_W-1:0]);
    wb = setup_b_t'(hwdata_i[`BUCK1_REG_W-1:0]);
    bus_next = bus_reg;
    addr_next = addr_reg;
    wr_next = wr_reg;
    ready_next = ready_reg;
    rdata_next = rdata_reg;
    a_next = a_reg;
    b_next = b_reg;
    idx = addr_reg >> `BUCK1_IDX_SHIFT;
    status_word = '0;
    status_word[`BUCK1_STS_UV_BIT] = uvf_reg;
    status_word[`BUCK1_STS_RAMP_BIT] = ramp_run;
    status_word[`BUCK1_STS_HC_BIT] = hcf_reg;
    case (bus_reg)
      BUS_IDLE:
      begin
        if (hsel_i && htrans_i[1] && hready_i)
        begin
          addr_next = haddr_i;
          wr_next = hwrite_i;
          ready_next = 1'b0;
          bus_next = BUS_WAIT;
        end
      end
      BUS_WAIT:
      begin
        // one wait state: write data is stable and read data comes from a flop
        ready_next = 1'b1;
        bus_next = BUS_IDLE;
        rdata_next = '0;
        if (idx == 32'(`BUCK1_SETUP_A_IDX))
        begin
          if (wr_reg)
          begin
            a_next.buck1_ramp_interval = wa.buck1_ramp_interval; // [RQ2]
            a_next.buck1_clock_invert = wa.buck1_clock_invert; // [RQ3]
            a_next.buck1_output_float = wa.buck1_output_float; // [RQ6]
            a_next.buck1_softstart_step = wa.buck1_softstart_step; // [RQ7]
            if (cfg_load)
            begin
              a_next.buck1_switch_rate_sel = wa.buck1_switch_rate_sel; // [RQ5] [RQ4]
              a_next.buck1_capacitor_range = wa.buck1_capacitor_range; // [RQ5] [RQ8]
            end
          end
          else
            rdata_next = 32'(a_reg);
        end
        else if (idx == 32'(`BUCK1_SETUP_B_IDX))
        begin
          if (wr_reg)
          begin
            b_next.buck1_undervoltage_action = wb.buck1_undervoltage_action; // [RQ9]
            b_next.buck1_hwctl_source = wb.buck1_hwctl_source; // [RQ11]
            b_next.buck1_hwctl_voltage_pick = wb.buck1_hwctl_voltage_pick; // [RQ12]
            b_next.buck1_hwctl_op_mode = wb.buck1_hwctl_op_mode; // [RQ13]
            b_next.buck1_overload_threshold = wb.buck1_overload_threshold; // [RQ14]
            b_next.buck1_overload_detect_en = wb.buck1_overload_detect_en; // [RQ15]
          end
          else
            rdata_next = 32'(b_reg);
        end
        else if (idx == 32'(`BUCK1_STATUS_IDX))
        begin
          if (!wr_reg)
            rdata_next = 32'(status_word); // [RQ16] [RQ17]
        end
      end
      default:
      begin
        bus_next = BUS_IDLE;
        ready_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bus_reg <= BUS_IDLE;
      addr_reg <= 32'h0;
      wr_reg <= 1'b0;
      ready_reg <= 1'b1;
      rdata_reg <= 32'h0;
      a_reg <= '{buck1_ramp_interval: `BUCK1_RAMP_RST, // [RQ2]
                 buck1_clock_invert: `BUCK1_INVERT_RST,
                 buck1_switch_rate_sel: `BUCK1_RATE_SEL_RST,
                 buck1_output_float: `BUCK1_FLOAT_RST,
                 buck1_softstart_step: `BUCK1_SS_RST,
                 buck1_capacitor_range: `BUCK1_CAP_RST,
                 default: '0};
      b_reg <= '{buck1_undervoltage_action: UV_IGNORE,
                 buck1_hwctl_source: `BUCK1_SRC_RST,
                 buck1_hwctl_voltage_pick: `BUCK1_VPICK_RST,
                 buck1_hwctl_op_mode: MODE_HYST, // [RQ13]
                 buck1_overload_threshold: `BUCK1_THR_RST,
                 buck1_overload_detect_en: `BUCK1_DET_RST, // [RQ15]
                 default: '0};
    end
    else
    begin
      bus_reg <= bus_next;
      addr_reg <= addr_next;
      wr_reg <= wr_next;
      ready_reg <= ready_next;
      rdata_reg <= rdata_next;
      a_reg <= a_next;
      b_reg <= b_next;
    end
  end

  // interval timers
  assign ramp_period = TW'(RAMP_BASE_CYCLES)
    << (`BUCK1_RAMP_FASTEST - a_reg.buck1_ramp_interval); // [RQ1]
  assign ss_period = TW'(SS_BASE_CYCLES) << a_reg.buck1_softstart_step; // [RQ7]
  assign ramp_run = (ps_reg == PS_RUN) && (vout_reg != target)
    && (a_reg.buck1_ramp_interval != `BUCK1_RAMP_IMMEDIATE);

  step_timer #(.W(TW)) u_ramp_tmr (
    .clk_i(clk_i),
    .rst_b_i(rst_n),
    .run_i(ramp_run),
    .period_i(ramp_period),
    .tick_o(ramp_tick)
  );

  step_timer #(.W(TW)) u_ss_tmr (
    .clk_i(clk_i),
    .rst_b_i(rst_n),
    .run_i(ps_reg == PS_SOFTSTART),
    .period_i(ss_period),
    .tick_o(ss_tick)
  );

  // operating point selection
  always_comb
  begin
    hw_active = (b_reg.buck1_hwctl_source[`BUCK1_HWC_IN1_BIT] & hw1_s)
      | (b_reg.buck1_hwctl_source[`BUCK1_HWC_IN2_BIT] & hw2_s); // [RQ11] [RQ19]
    eff_mode = hw_active ? b_reg.buck1_hwctl_op_mode : normal_mode_i; // [RQ13] [RQ19]
    if (hw_active && b_reg.buck1_hwctl_voltage_pick)
      target = buck1_sleep_voltage_i; // [RQ12]
    else
      target = buck1_on_voltage_i; // [RQ19]
    want_on = enable_i && (eff_mode != MODE_OFF) && !conv_off_reg;
    uv_rise = uv_s && !uv_prev_reg;
  end

  // power sequencing, ramp and undervoltage handling
  always_comb
  begin
    ps_next = ps_reg;
    ss_next = ss_reg;
    vout_next = vout_reg;
    uv_prev_next = uv_s;
    irq_next = uv_rise; // [RQ10]
    rstreq_next = uv_rise && (b_reg.buck1_undervoltage_action == UV_SYS_RESET); // [RQ9]
    // a new undervoltage beats the clear caused by software disabling
    if (uv_s && (b_reg.buck1_undervoltage_action == UV_CONV_OFF))
      conv_off_next = 1'b1; // [RQ9]
    else if (!enable_i)
      conv_off_next = 1'b0;
    else
      conv_off_next = conv_off_reg;
    uvf_next = uv_s; // [RQ16]
    hcf_next = b_reg.buck1_overload_detect_en && oc_s; // [RQ15] [RQ17]
    case (ps_reg)
      PS_OFF:
      begin
        ss_next = 3'h0;
        if (want_on)
          ps_next = PS_SOFTSTART;
      end
      PS_SOFTSTART:
      begin
        if (!want_on)
          ps_next = PS_OFF;
        else if (ss_tick)
        begin
          if (ss_reg == `BUCK1_SS_LAST)
            ps_next = PS_RUN; // [RQ7]
          else
            ss_next = ss_reg + 3'h1; // [RQ7]
        end
      end
      PS_RUN:
      begin
        if (!want_on)
          ps_next = PS_OFF;
      end
      default:
        ps_next = PS_OFF;
    endcase
    // off or starting: sit on the target so the ramp starts from it
    if (ps_reg != PS_RUN)
      vout_next = target;
    else if (a_reg.buck1_ramp_interval == `BUCK1_RAMP_IMMEDIATE)
      vout_next = target; // [RQ1]
    else if (ramp_tick && (vout_reg < target))
      vout_next = vout_reg + vcode_t'(1); // [RQ18]
    else if (ramp_tick && (vout_reg > target))
      vout_next = vout_reg - vcode_t'(1); // [RQ18]
    stage_next.enable = (ps_reg != PS_OFF);
    stage_next.discharge = (ps_reg == PS_OFF) && !a_reg.buck1_output_float; // [RQ6]
    stage_next.clock_invert = a_reg.buck1_clock_invert; // [RQ3]
    stage_next.switch_rate_sel = a_reg.buck1_switch_rate_sel; // [RQ4]
    stage_next.capacitor_range = a_reg.buck1_capacitor_range; // [RQ8]
    stage_next.op_mode = eff_mode; // [RQ13]
    stage_next.softstart_level = ss_reg;
    stage_next.overload_threshold = b_reg.buck1_overload_threshold; // [RQ14]
    stage_next.overload_detect_en = b_reg.buck1_overload_detect_en;
    stage_next.voltage = vout_reg;
  end

  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ps_reg <= PS_OFF;
      ss_reg <= 3'h0;
      vout_reg <= '0;
      conv_off_reg <= 1'b0;
      uv_prev_reg <= 1'b0;
      irq_reg <= 1'b0;
      rstreq_reg <= 1'b0;
      uvf_reg <= 1'b0;
      hcf_reg <= 1'b0;
      stage_reg <= '{op_mode: MODE_FCCM, default: '0};
    end
    else
    begin
      ps_reg <= ps_next;
      ss_reg <= ss_next;
      vout_reg <= vout_next;
      conv_off_reg <= conv_off_next;
      uv_prev_reg <= uv_prev_next;
      irq_reg <= irq_next;
      rstreq_reg <= rstreq_next;
      uvf_reg <= uvf_next;
      hcf_reg <= hcf_next;
      stage_reg <= stage_next;
    end
  end

  // outputs, all from flops except hresp_o, which is tied low
  assign hreadyout_o = ready_reg;
  assign hresp_o = 1'b0;
  assign hrdata_o = rdata_reg;
  assign stage_o = stage_reg;
  assign buck1_undervoltage_flag_o = uvf_reg;
  assign buck1_overload_flag_o = hcf_reg;
  assign uv_irq_o = irq_reg;
  assign sys_reset_req_o = rstreq_reg;
endmodule

// ### bench/buck1_stage_model.sv
// behavioural model of the analogue power stage behind buck1
module buck1_stage_model (
  // settings from the control block
  input wire buck1_pkg::stage_ctrl_t stage_i,
  // fault and load commanded by the bench
  input wire logic uv_fault_i,
  input wire logic [15:0] load_ma_i,
  // comparator pins
  output logic undervoltage_o,
  output logic overload_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import buck1_pkg::*;
  assign undervoltage_o = uv_fault_i;
  // comparator only; detect enable is left to the control block
  assign overload_o = 32'(load_ma_i) > 125 * (32'(stage_i.overload_threshold) + 1);
endmodule

// ### bench/buck1_control_checker.sv
// port assertions for the buck1 control block
module buck1_control_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // bus
  input wire logic hsel_i,
  input wire logic [1:0] htrans_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [31:0] hrdata_o,
  // stage and events
  input wire buck1_pkg::stage_ctrl_t stage_o,
  input wire logic buck1_undervoltage_flag_o,
  input wire logic buck1_overload_flag_o,
  input wire logic uv_irq_o,
  input wire logic sys_reset_req_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import buck1_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  a_okay_resp: assert property (hresp_o == 1'b0)
    else $error("response not okay");
  a_one_wait: assert property (hsel_i && htrans_i[1] && hready_i && hreadyout_o
    |=> !hreadyout_o ##1 hreadyout_o) else $error("wait state wrong");
  a_rdata_hold: assert property ($changed(hrdata_o) |-> $rose(hreadyout_o))
    else $error("read data moved outside completion");
  a_irq_pulse: assert property (uv_irq_o |=> !uv_irq_o)
    else $error("interrupt longer than one cycle");
  a_irq_flag: assert property (uv_irq_o |-> ##[0:2] buck1_undervoltage_flag_o)
    else $error("interrupt without undervoltage flag");
  a_reset_pulse: assert property (sys_reset_req_o |-> uv_irq_o ##1 !sys_reset_req_o)
    else $error("reset request not tied to interrupt");
  a_ovl_gated: assert property (buck1_overload_flag_o |-> stage_o.overload_detect_en)
    else $error("overload flag while detection off");
  a_discharge_off: assert property (stage_o.discharge |-> !stage_o.enable)
    else $error("discharge while enabled");
  a_ss_count: assert property ($changed(stage_o.softstart_level) |->
    stage_o.softstart_level == $past(stage_o.softstart_level) + 3'h1
    || stage_o.softstart_level == 3'h0) else $error("soft-start level skipped");
  a_ss_dwell: assert property ($changed(stage_o.softstart_level) &&
    stage_o.softstart_level != 3'h0 |=> $stable(stage_o.softstart_level)[*3])
    else $error("soft-start step too short");
endmodule
bind buck1_control buck1_control_checker u_buck1_control_checker (.clk_i, .rst_b_i, .hsel_i,
  .htrans_i, .hready_i, .hreadyout_o, .hresp_o, .hrdata_o, .stage_o,
  .buck1_undervoltage_flag_o, .buck1_overload_flag_o, .uv_irq_o, .sys_reset_req_o);

// ### bench/buck1_control_bench.sv
// self-checking bench for the buck1 control block
`include "buck1_map.svh"
module buck1_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import buck1_pkg::*;
  localparam logic [31:0] A_ADR = 32'(`BUCK1_SETUP_A_IDX) << `BUCK1_IDX_SHIFT;
  localparam logic [31:0] B_ADR = 32'(`BUCK1_SETUP_B_IDX) << `BUCK1_IDX_SHIFT;
  localparam logic [31:0] S_ADR = 32'(`BUCK1_STATUS_IDX) << `BUCK1_IDX_SHIFT;
  typedef struct {logic [31:0] adr; logic [15:0] wd; logic [31:0] exp; logic inv;
    logic dis;} row_t;
  logic clk_i = 1'b0, rst_b_i = 1'b0, hsel_i = 1'b0, hwrite_i = 1'b0;
  logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o, rd;
  logic [1:0] htrans_i = 2'h0;
  logic otp_load_i = 1'b0, eeprom_config_load_i = 1'b0, enable_i = 1'b0;
  logic hwctl1_i = 1'b0, hwctl2_i = 1'b0, uv_fault = 1'b0, act;
  logic [15:0] load_ma = 16'h0;
  logic hreadyout_o, hresp_o, uv_pin, ovl_pin, uv_irq_o, sys_reset_req_o;
  logic buck1_undervoltage_flag_o, buck1_overload_flag_o;
  stage_ctrl_t stage_o;
  int n_mismatch = 0, n_checks = 0, ni, nr;
  int tq[$];
  row_t rows[5] = '{
    '{A_ADR, 16'hFFFF, 32'hD0B0, 1'b1, 1'b0},
    '{A_ADR, 16'h0000, 32'h0000, 1'b0, 1'b1},
    '{B_ADR, 16'hFFFF, 32'hDF71, 1'b0, 1'b1},
    '{S_ADR, 16'hFFFF, 32'h0000, 1'b0, 1'b1},
    '{32'h10164, 16'hFFFF, 32'h0000, 1'b0, 1'b1}};
  always #10 clk_i = ~clk_i;
  // short counts keep the timed scenarios brief
  buck1_control #(.RAMP_BASE_CYCLES(4), .SS_BASE_CYCLES(4)) u_buck1_control (.clk_i,
    .rst_b_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i,
    .hready_i(hreadyout_o), .hreadyout_o, .hresp_o, .hrdata_o, .otp_load_i,
    .eeprom_config_load_i, .enable_i, .normal_mode_i(MODE_FCCM),
    .buck1_on_voltage_i(7'h20), .buck1_sleep_voltage_i(7'h1C), .hwctl1_i, .hwctl2_i,
    .undervoltage_i(uv_pin), .overload_i(ovl_pin), .stage_o, .buck1_undervoltage_flag_o,
    .buck1_overload_flag_o, .uv_irq_o, .sys_reset_req_o);
  buck1_stage_model u_buck1_stage_model (.stage_i(stage_o), .uv_fault_i(uv_fault),
    .load_ma_i(load_ma), .undervoltage_o(uv_pin), .overload_o(ovl_pin));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  // no local limit on the waits: a hung slave is left to the watchdog
  task automatic bus(input logic w, input logic [31:0] a, input logic [15:0] wd);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= w;
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= {16'h0, wd};
    do @(posedge clk_i); while (hreadyout_o !== 1'b1);
    rd = hrdata_o;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // change times of the soft-start level or the voltage code
  task automatic watch(input bit lvl, input int n);
    logic [6:0] v;
    tq = {};
    for (int t = 0; t < n; t++)
    begin
      v = lvl ? 7'(stage_o.softstart_level) : stage_o.voltage;
      @(posedge clk_i);
      if ((lvl ? 7'(stage_o.softstart_level) : stage_o.voltage) !== v)
        tq.push_back(t);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    #400000;
    n_mismatch++;
    give_verdict();
  end
  initial
  begin
    tick(5);
    chk("stage in reset", stage_o, 32'h0);
    chk("ready in reset", hreadyout_o, 32'h1);
    tick(1);
    rst_b_i <= 1'b1;
    tick(3);
    bus(1'b0, A_ADR, 16'h0);
    chk("setup_a reset", rd, 32'h8000);
    bus(1'b0, B_ADR, 16'h0);
    chk("setup_b reset", rd, 32'h0300);
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].adr, rows[i].wd);
      bus(1'b0, rows[i].adr, 16'h0);
      chk("readback", rd, rows[i].exp);
      chk("clock invert", stage_o.clock_invert, rows[i].inv);
      chk("discharge", stage_o.discharge, rows[i].dis);
    end
    // locked fields open only while a loader runs
    otp_load_i <= 1'b1;
    bus(1'b1, A_ADR, 16'h0302);
    otp_load_i <= 1'b0;
    bus(1'b0, A_ADR, 16'h0);
    chk("load otp", rd, 32'h0302);
    eeprom_config_load_i <= 1'b1;
    bus(1'b1, A_ADR, 16'h0100);
    eeprom_config_load_i <= 1'b0;
    bus(1'b1, A_ADR, 16'h0000);
    bus(1'b0, A_ADR, 16'h0);
    chk("load eeprom", rd, 32'h0100);
    chk("rate out", stage_o.switch_rate_sel, 32'h1);
    chk("cap out", stage_o.capacitor_range, 32'h0);
    enable_i <= 1'b1;
    bus(1'b1, A_ADR, 16'hC000);
    tick(60);
    for (int c = 0; c < 8; c++)
    begin
      bus(1'b1, B_ADR, {3'h0, c[2:1], 3'h6, 8'h0});
      hwctl1_i <= ~c[0];
      hwctl2_i <= c[0];
      tick(8);
      act = (c[1] & ~c[0]) | (c[2] & c[0]);
      chk("hw mode", stage_o.op_mode, act ? MODE_LDO : MODE_FCCM);
      chk("hw volt", stage_o.voltage, act ? 7'h1C : 7'h20);
    end
    hwctl2_i <= 1'b0;
    for (int s = 0; s < 4; s++)
    begin
      enable_i <= 1'b0;
      bus(1'b1, A_ADR, {2'h3, 8'h0, s[1:0], 4'h0});
      enable_i <= 1'b1;
      watch(1'b1, 300);
      chk("ss steps", tq.size() >= 7, 32'h1);
      chk("ss step len", tq[2] - tq[1], 4 << s);
    end
    tick(40);
    bus(1'b1, B_ADR, 16'h0C00);
    for (int r = 0; r < 3; r++)
    begin
      bus(1'b1, A_ADR, {r[1:0], 14'h0});
      hwctl1_i <= ~hwctl1_i;
      watch(1'b0, 300);
      chk("ramp steps", tq.size(), 32'h4);
      chk("ramp gap", tq[2] - tq[1], 4 << (2 - r));
      chk("ramp end", stage_o.voltage, hwctl1_i ? 7'h1C : 7'h20);
    end
    for (int a = 0; a < 3; a++)
    begin
      bus(1'b1, B_ADR, {a[1:0], 14'h0300});
      enable_i <= 1'b0;
      tick(2);
      enable_i <= 1'b1;
      tick(60);
      uv_fault <= 1'b1;
      ni = 0;
      nr = 0;
      repeat (12)
      begin
        @(posedge clk_i);
        ni += uv_irq_o;
        nr += sys_reset_req_o;
      end
      chk("uv irq", ni, 32'h1);
      chk("sys reset", nr, a == 2);
      bus(1'b0, S_ADR, 16'h0);
      chk("uv status", rd[0], 32'h1);
      chk("uv flag", buck1_undervoltage_flag_o, 32'h1);
      uv_fault <= 1'b0;
      tick(8);
      chk("uv flag clear", buck1_undervoltage_flag_o, 32'h0);
      chk("conv on", stage_o.enable, a != 1);
    end
    load_ma <= 16'h01F4;
    for (int t = 0; t < 9; t++)
    begin
      bus(1'b1, B_ADR, {9'h006, t[2:0], 3'h0, t < 8});
      tick(8);
      chk("overload", buck1_overload_flag_o, t < 3);
      chk("threshold out", stage_o.overload_threshold, t[2:0]);
      chk("detect out", stage_o.overload_detect_en, t < 8);
    end
    give_verdict();
  end
endmodule
